//--- svpe_pkg.sv
package svpe_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLOCK_HZ = 50_000_000;
    localparam int REPLY_WAIT_MS = 30;
    localparam int REPLY_WAIT_CYCLES = (CLOCK_HZ / 1000) * REPLY_WAIT_MS;
    localparam int TIMER_WIDTH = 24;

    // ------------------------------------------------------------
    // Message command codes
    // ------------------------------------------------------------
    localparam logic [2:0] CMD_NONE = 3'h0;
    localparam logic [2:0] CMD_IDENTITY = 3'h1;
    localparam logic [2:0] CMD_VENDOR_IDS = 3'h2;
    localparam logic [2:0] CMD_MODES = 3'h3;
    localparam logic [2:0] CMD_ENTER = 3'h4;
    localparam logic [2:0] CMD_EXIT = 3'h5;
    localparam logic [2:0] CMD_ATTENTION = 3'h6;

    // Command type carried with each message
    localparam logic [1:0] KIND_REQUEST = 2'h0;
    localparam logic [1:0] KIND_ACK = 2'h1;
    localparam logic [1:0] KIND_NAK = 2'h2;
    localparam logic [1:0] KIND_BUSY = 2'h3;

    // Outcome reported to the policy manager
    localparam logic [1:0] RESULT_ACK = 2'h0;
    localparam logic [1:0] RESULT_NAK = 2'h1;
    localparam logic [1:0] RESULT_BUSY = 2'h2;
    localparam logic [1:0] RESULT_TIMEOUT = 2'h3;

    localparam int DATA_WIDTH = 32;

    typedef struct packed {
        logic [2:0] cmd;
        logic [1:0] kind;
        logic [DATA_WIDTH-1:0] data;
    } svpe_msg_t;

    typedef struct packed {
        logic [2:0] cmd;
        logic [1:0] result;
        logic [DATA_WIDTH-1:0] data;
    } svpe_report_t;

endpackage : svpe_pkg

//--- svpe_reply_timer.sv
`timescale 1ns/100ps
module svpe_reply_timer #(
    parameter int unsigned CYCLES = svpe_pkg::REPLY_WAIT_CYCLES
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic start,
    input wire logic stop,
    output logic expired
);
    import svpe_pkg::*;

    localparam logic [TIMER_WIDTH-1:0] LOAD = TIMER_WIDTH'(CYCLES);
    logic [TIMER_WIDTH-1:0] count;
    logic running;
    wire atEnd = running && (count == TIMER_WIDTH'(1));

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            count <= '0;
            running <= 1'b0;
            expired <= 1'b0;
        end else begin
            expired <= atEnd && !start && !stop;
            if (start) begin
                count <= LOAD;
                running <= 1'b1;
            end else if (stop || atEnd) begin
                running <= 1'b0;
            end else if (running) begin
                count <= count - TIMER_WIDTH'(1);
            end
        end
    end
endmodule : svpe_reply_timer

//--- svpe_msg_latch.sv
`timescale 1ns/100ps
module svpe_msg_latch (
    input wire logic clock,
    input wire logic rst,
    input wire logic load,
    input wire svpe_pkg::svpe_msg_t nextValue,
    output svpe_pkg::svpe_msg_t value
);
    import svpe_pkg::*;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            value <= '0;
        end else if (load) begin
            value <= nextValue;
        end
    end
endmodule : svpe_msg_latch

//--- svpe_engine.sv
`timescale 1ns/100ps
// Behaviour
// - Identity request: fetch identity, send ACK
// - Vendor ID request: fetch, send ACK, return
// - Modes request: fetch, send ACK, return
// - Enter request: manager judges and enters mode
// - Mode entered: send entry ACK, return
// - Entry refused: send NAK as manager says
// - Exit request: manager leaves named mode
// - Mode left: send exit ACK, return
// - Manager attention: send Attention, return
// - Identity handled only in normal/safe operation
// - Identity query: send request, start timer
// - Identity ACK in time: deliver data
// - Identity NAK/BUSY/timeout: report which
// - Vendor ID query: send request, start timer
// - Vendor ID ACK: deliver data
// - Vendor ID NAK/BUSY/timeout: report which
module svpe_engine #(
    parameter int unsigned REPLY_WAIT = svpe_pkg::REPLY_WAIT_CYCLES
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic powerRoleSource,
    input wire logic safeOrNormalOp,
    input wire logic rxValid,
    input wire svpe_pkg::svpe_msg_t rxMsg,
    output logic txValid,
    output svpe_pkg::svpe_msg_t txMsg,
    input wire logic txDone,
    output logic pmFetch,
    output logic [2:0] pmFetchCmd,
    output svpe_pkg::svpe_msg_t pmRequestMsg,
    input wire logic pmDataValid,
    input wire logic [31:0] pmData,
    input wire logic pmEntryNak,
    input wire logic [1:0] pmNakKind,
    input wire logic pmAttention,
    input wire logic pmQueryIdentity,
    input wire logic pmQueryVendorIds,
    output logic reportValid,
    output svpe_pkg::svpe_report_t report,
    input wire logic reportTaken,
    output logic sourceIdle,
    output logic sinkIdle
);
    import svpe_pkg::*;

    // ------------------------------------------------------------
    // States
    // ------------------------------------------------------------
    typedef enum logic [17:0] {
        source_idle_state = 18'h00001,
        sink_idle_state = 18'h00002,
        resp_fetch_identity = 18'h00004,
        resp_reply_identity = 18'h00008,
        resp_fetch_vendor_ids = 18'h00010,
        resp_reply_vendor_ids = 18'h00020,
        resp_fetch_modes = 18'h00040,
        resp_reply_modes = 18'h00080,
        resp_judge_entry = 18'h00100,
        resp_entry_accept = 18'h00200,
        resp_entry_refuse = 18'h00400,
        resp_leave_mode = 18'h00800,
        resp_leave_accept = 18'h01000,
        resp_attention_send = 18'h02000,
        init_identity_query = 18'h04000,
        init_vendor_id_query = 18'h08000,
        init_done = 18'h10000,
        init_fail = 18'h20000
    } svpe_state_t;

    svpe_state_t state;
    svpe_state_t next_state;
    svpe_state_t readyState;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    wire atReady = (state == source_idle_state) || (state == sink_idle_state);
    wire rxRequest = rxValid && (rxMsg.kind == KIND_REQUEST);
    wire rxReply = rxValid && (rxMsg.kind != KIND_REQUEST);
    wire reqIdentity = atReady && rxRequest && (rxMsg.cmd == CMD_IDENTITY) && safeOrNormalOp;
    wire reqVendor = atReady && rxRequest && (rxMsg.cmd == CMD_VENDOR_IDS);
    wire reqModes = atReady && rxRequest && (rxMsg.cmd == CMD_MODES);
    wire reqEnter = atReady && rxRequest && (rxMsg.cmd == CMD_ENTER);
    wire reqExit = atReady && rxRequest && (rxMsg.cmd == CMD_EXIT);
    wire anyRxReq = reqIdentity || reqVendor || reqModes || reqEnter || reqExit;
    wire waiting = (state == init_identity_query) || (state == init_vendor_id_query);
    wire [2:0] waitCmd = (state == init_identity_query) ? CMD_IDENTITY : CMD_VENDOR_IDS;
    wire replyMatch = waiting && rxReply && (rxMsg.cmd == waitCmd);
    wire replyAck = replyMatch && (rxMsg.kind == KIND_ACK);
    wire replyFail = replyMatch && (rxMsg.kind != KIND_ACK);
    wire timerExpired;
    wire timeoutHit = waiting && timerExpired && !replyMatch;
    wire startQuery = atReady && !anyRxReq && !pmAttention
        && (pmQueryIdentity || pmQueryVendorIds);

    // ------------------------------------------------------------
    // Reply timer
    // ------------------------------------------------------------
    svpe_reply_timer #(.CYCLES(REPLY_WAIT)) replyTimer (
        .clock(clock),
        .rst(rst),
        .start(startQuery),
        .stop(replyMatch),
        .expired(timerExpired)
    );

    // ------------------------------------------------------------
    // Held copy of the request under service
    // ------------------------------------------------------------
    svpe_msg_latch requestLatch (
        .clock(clock),
        .rst(rst),
        .load(anyRxReq),
        .nextValue(rxMsg),
        .value(pmRequestMsg)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        readyState = powerRoleSource ? source_idle_state : sink_idle_state;
        next_state = state;
        unique case (state)
            source_idle_state, sink_idle_state: begin
                if (reqIdentity) begin
                    next_state = resp_fetch_identity;
                end else if (reqVendor) begin
                    next_state = resp_fetch_vendor_ids;
                end else if (reqModes) begin
                    next_state = resp_fetch_modes;
                end else if (reqEnter) begin
                    next_state = resp_judge_entry;
                end else if (reqExit) begin
                    next_state = resp_leave_mode;
                end else if (pmAttention) begin
                    next_state = resp_attention_send;
                end else if (pmQueryIdentity) begin
                    next_state = init_identity_query;
                end else if (pmQueryVendorIds) begin
                    next_state = init_vendor_id_query;
                end else begin
                    next_state = readyState;
                end
            end
            resp_fetch_identity: begin
                if (pmDataValid) begin
                    next_state = resp_reply_identity;
                end
            end
            resp_fetch_vendor_ids: begin
                if (pmDataValid) begin
                    next_state = resp_reply_vendor_ids;
                end
            end
            resp_fetch_modes: begin
                if (pmDataValid) begin
                    next_state = resp_reply_modes;
                end
            end
            resp_judge_entry: begin
                if (pmEntryNak) begin
                    next_state = resp_entry_refuse;
                end else if (pmDataValid) begin
                    next_state = resp_entry_accept;
                end
            end
            resp_leave_mode: begin
                if (pmDataValid) begin
                    next_state = resp_leave_accept;
                end
            end
            resp_reply_identity, resp_reply_vendor_ids, resp_reply_modes,
            resp_entry_accept, resp_entry_refuse, resp_leave_accept,
            resp_attention_send: begin
                if (txDone) begin
                    next_state = readyState;
                end
            end
            init_identity_query, init_vendor_id_query: begin
                if (replyAck) begin
                    next_state = init_done;
                end else if (replyFail || timeoutHit) begin
                    next_state = init_fail;
                end
            end
            init_done, init_fail: begin
                if (reportTaken) begin
                    next_state = readyState;
                end
            end
            default: begin
                next_state = readyState;
            end
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state <= sink_idle_state;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------
    // Outgoing message
    // ------------------------------------------------------------
    wire enterSend = (next_state != state);
    wire sendNow = enterSend && (next_state inside {resp_reply_identity,
        resp_reply_vendor_ids, resp_reply_modes, resp_entry_accept,
        resp_entry_refuse, resp_leave_accept, resp_attention_send,
        init_identity_query, init_vendor_id_query});
    logic [2:0] next_txCmd;
    logic [1:0] next_txKind;

    always_comb begin
        next_txCmd = CMD_NONE;
        next_txKind = KIND_ACK;
        unique case (next_state)
            resp_reply_identity: next_txCmd = CMD_IDENTITY;
            resp_reply_vendor_ids: next_txCmd = CMD_VENDOR_IDS;
            resp_reply_modes: next_txCmd = CMD_MODES;
            resp_entry_accept: next_txCmd = CMD_ENTER;
            resp_entry_refuse: begin
                next_txCmd = CMD_ENTER;
                next_txKind = (pmNakKind == KIND_BUSY) ? KIND_BUSY : KIND_NAK;
            end
            resp_leave_accept: next_txCmd = CMD_EXIT;
            resp_attention_send: begin
                next_txCmd = CMD_ATTENTION;
                next_txKind = KIND_REQUEST;
            end
            init_identity_query: begin
                next_txCmd = CMD_IDENTITY;
                next_txKind = KIND_REQUEST;
            end
            init_vendor_id_query: begin
                next_txCmd = CMD_VENDOR_IDS;
                next_txKind = KIND_REQUEST;
            end
            default: begin
                next_txCmd = CMD_NONE;
            end
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            txValid <= 1'b0;
            txMsg <= '0;
        end else begin
            if (sendNow) begin
                txValid <= 1'b1;
                txMsg.cmd <= next_txCmd;
                txMsg.kind <= next_txKind;
                txMsg.data <= pmDataValid ? pmData : '0;
            end else if (txDone) begin
                txValid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Policy manager side
    // ------------------------------------------------------------
    wire fetchState = (state inside {resp_fetch_identity, resp_fetch_vendor_ids,
        resp_fetch_modes, resp_judge_entry, resp_leave_mode});
    wire [1:0] failResult = timeoutHit ? RESULT_TIMEOUT
        : (rxMsg.kind == KIND_BUSY) ? RESULT_BUSY : RESULT_NAK;

    assign pmFetch = fetchState;
    assign pmFetchCmd = pmRequestMsg.cmd;
    assign reportValid = (state == init_done) || (state == init_fail);
    assign sourceIdle = (state == source_idle_state);
    assign sinkIdle = (state == sink_idle_state);

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            report <= '0;
        end else if (replyAck || replyFail || timeoutHit) begin
            report.cmd <= waitCmd;
            report.result <= replyAck ? RESULT_ACK : failResult;
            report.data <= replyAck ? rxMsg.data : '0;
        end
    end

endmodule : svpe_engine

//--- svpe_engine_props.sv
`timescale 1ns/100ps
// ----
// Engine checker
// ----
module svpe_engine_props (
    input wire logic clock,
    input wire logic rst,
    input wire logic safeOrNormalOp,
    input wire logic rxValid,
    input wire svpe_pkg::svpe_msg_t rxMsg,
    input wire logic txValid,
    input wire svpe_pkg::svpe_msg_t txMsg,
    input wire logic txDone,
    input wire logic pmFetch,
    input wire logic [2:0] pmFetchCmd,
    input wire logic pmDataValid,
    input wire logic [31:0] pmData,
    input wire logic pmEntryNak,
    input wire logic [1:0] pmNakKind,
    input wire logic pmAttention,
    input wire logic pmQueryIdentity,
    input wire logic pmQueryVendorIds,
    input wire logic reportValid,
    input wire svpe_pkg::svpe_report_t report,
    input wire logic reportTaken,
    input wire logic sourceIdle,
    input wire logic sinkIdle
);
    import svpe_pkg::*;
    default clocking @(posedge clock);
    endclocking
    default disable iff (rst);
    wire idle = sourceIdle || sinkIdle;
    wire rxId = rxValid && rxMsg.kind == KIND_REQUEST && rxMsg.cmd == CMD_IDENTITY;
    wire anyQuery = pmQueryIdentity || pmQueryVendorIds;
    a_fetch_identity: assert property (idle && rxId && safeOrNormalOp
        |=> pmFetch && pmFetchCmd == CMD_IDENTITY) else $error("identity not fetched");
    a_identity_gated: assert property (idle && rxId && !safeOrNormalOp
        && !pmAttention && !anyQuery |=> !pmFetch && !txValid) else $error("identity not gated");
    a_fetch_holds: assert property (pmFetch && !pmDataValid && !pmEntryNak
        |=> pmFetch && $stable(pmFetchCmd)) else $error("fetch dropped");
    a_ack_reply: assert property (pmFetch && pmDataValid && !pmEntryNak
        |=> txValid && txMsg.kind == KIND_ACK && txMsg.data == $past(pmData)
        && txMsg.cmd == $past(pmFetchCmd)) else $error("bad ack reply");
    a_nak_reply: assert property (pmFetch && pmFetchCmd == CMD_ENTER && pmEntryNak
        |=> txValid && txMsg.cmd == CMD_ENTER
        && txMsg.kind == ($past(pmNakKind) == 2'h3 ? KIND_BUSY : KIND_NAK)) else $error("bad nak");
    a_tx_stands: assert property (txValid && !txDone |=> txValid && $stable(txMsg))
        else $error("tx not held");
    a_back_ready: assert property (txValid && txDone
        && (txMsg.kind != KIND_REQUEST || txMsg.cmd == CMD_ATTENTION) |=> idle)
        else $error("no return to ready");
    a_attention_sent: assert property (idle && pmAttention && !rxValid
        |=> txValid && txMsg.cmd == CMD_ATTENTION && txMsg.kind == KIND_REQUEST)
        else $error("attention not sent");
    a_query_sent: assert property (idle && !rxValid && !pmAttention && anyQuery
        |=> txValid && txMsg.kind == KIND_REQUEST
        && txMsg.cmd == ($past(pmQueryIdentity) ? CMD_IDENTITY : CMD_VENDOR_IDS))
        else $error("query not sent");
    a_report_stands: assert property (reportValid && !reportTaken
        |=> reportValid && $stable(report)) else $error("report not held");
    c_refusal: cover property (pmFetch && pmEntryNak);
    c_timeout: cover property (reportValid && report.result == RESULT_TIMEOUT);
    c_attention: cover property (txValid && txMsg.cmd == CMD_ATTENTION);
endmodule : svpe_engine_props
bind svpe_engine svpe_engine_props svpe_engine_props_inst (.*);

//--- svpe_link_partner.sv
`timescale 1ns/100ps
// ----
// Link partner
// ----
module svpe_link_partner (
    input wire logic clock,
    input wire logic txValid,
    input wire svpe_pkg::svpe_msg_t txMsg,
    input wire logic replyOn,
    input wire logic [1:0] replyKind,
    output logic txDone,
    output logic rxValid,
    output svpe_pkg::svpe_msg_t rxMsg
);
    import svpe_pkg::*;
    logic slow = 1'b0;
    svpe_msg_t sent;
    task automatic sendMsg(input logic [2:0] cmd, input logic [1:0] kind);
        rxMsg = {cmd, kind, 32'h5a5a_a5a5 ^ cmd};
        rxValid = 1'b1;
        @(negedge clock);
        rxValid = 1'b0;
        rxMsg = ~rxMsg;
    endtask : sendMsg
    initial begin
        txDone = 1'b0;
        rxValid = 1'b0;
        rxMsg = '0;
        forever begin
            @(negedge clock);
            if (txValid) begin
                sent = txMsg;
                repeat (slow ? 3 : 0) @(negedge clock);
                slow = !slow;
                txDone = 1'b1;
                @(negedge clock);
                txDone = 1'b0;
                if (replyOn && sent.kind == KIND_REQUEST && sent.cmd != CMD_ATTENTION) begin
                    @(negedge clock);
                    sendMsg(sent.cmd, replyKind);
                end
            end
        end
    end
endmodule : svpe_link_partner

//--- structured_vdm_policy_engine_tb.sv
`timescale 1ns/100ps
module structured_vdm_policy_engine_tb;
    import svpe_pkg::*;
    localparam int unsigned WAIT_CYCLES = 20;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic powerRoleSource = 1'b0, safeOrNormalOp = 1'b1, pmDataValid = 1'b0, pmEntryNak = 1'b0;
    logic pmAttention = 1'b0, pmQueryIdentity = 1'b0, pmQueryVendorIds = 1'b0;
    logic reportTaken = 1'b0, replyOn = 1'b0, txDone, rxValid, txValid, pmFetch;
    logic reportValid, sourceIdle, sinkIdle;
    logic [1:0] pmNakKind = 2'h0, replyKind = 2'h0;
    logic [2:0] pmFetchCmd;
    logic [31:0] pmData = 32'h0;
    svpe_msg_t rxMsg, txMsg, pmRequestMsg;
    svpe_report_t report;
    int n_mismatch = 0, num_checks = 0, cycles = 0, k;
    svpe_engine #(.REPLY_WAIT(WAIT_CYCLES)) svpe_engine_inst (.*);
    svpe_link_partner svpe_link_partner_inst (.*);
    always #10 clock = ~clock;
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : wrap_up
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_mismatch++;
            wrap_up();
        end
    end
    task automatic chk(input string what, input logic [36:0] seen, input logic [36:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic waitIdle(input logic role);
        for (int i = 0; i < 20 && !(sourceIdle || sinkIdle); i++) @(negedge clock);
        chk("source idle", sourceIdle, role);
        chk("sink idle", sinkIdle, !role);
    endtask : waitIdle
    task automatic serve(input logic [2:0] cmd, input logic role, input logic no, input logic [1:0] how);
        powerRoleSource = role;
        pmData = 32'hbead_0000 | cmd;
        svpe_link_partner_inst.sendMsg(cmd, KIND_REQUEST);
        for (int i = 0; i < 8 && !pmFetch; i++) @(negedge clock);
        chk("fetch cmd", pmFetchCmd, cmd);
        chk("request", pmRequestMsg, {cmd, KIND_REQUEST, 32'h5a5a_a5a5 ^ cmd});
        repeat (2) @(negedge clock);
        chk("fetch held", pmFetch, 1'b1);
        pmEntryNak = no;
        pmNakKind = how;
        pmDataValid = !no;
        @(negedge clock);
        pmEntryNak = 1'b0;
        pmDataValid = 1'b0;
        chk("tx valid", txValid, 1'b1);
        if (no) chk("nak", {txMsg.cmd, txMsg.kind}, {CMD_ENTER, (how == 2'h3 ? KIND_BUSY : KIND_NAK)});
        else chk("ack", txMsg, {cmd, KIND_ACK, pmData});
        waitIdle(role);
        $display("serve %0d done", cmd);
    endtask : serve
    task automatic gateIdentity();
        safeOrNormalOp = 1'b0;
        svpe_link_partner_inst.sendMsg(CMD_IDENTITY, KIND_REQUEST);
        repeat (3) @(negedge clock);
        chk("gated", {pmFetch, txValid}, 2'h0);
        safeOrNormalOp = 1'b1;
        $display("gate done");
    endtask : gateIdentity
    task automatic attention();
        pmAttention = 1'b1;
        for (int i = 0; i < 8 && !txValid; i++) @(negedge clock);
        pmAttention = 1'b0;
        chk("attention", {txMsg.cmd, txMsg.kind}, {CMD_ATTENTION, KIND_REQUEST});
        waitIdle(powerRoleSource);
        $display("attention done");
    endtask : attention
    task automatic query(input logic [2:0] cmd, input logic [1:0] kind, input logic on);
        replyOn = on;
        replyKind = kind;
        pmQueryIdentity = (cmd == CMD_IDENTITY);
        pmQueryVendorIds = (cmd == CMD_VENDOR_IDS);
        @(negedge clock);
        pmQueryIdentity = 1'b0;
        pmQueryVendorIds = 1'b0;
        chk("query", {txMsg.cmd, txMsg.kind}, {cmd, KIND_REQUEST});
        for (int i = 0; i < WAIT_CYCLES + 30 && !reportValid; i++) @(negedge clock);
        chk("outcome", {report.cmd, report.result}, {cmd, (!on ? RESULT_TIMEOUT : (kind == KIND_ACK) ? RESULT_ACK : (kind == KIND_NAK) ? RESULT_NAK : RESULT_BUSY)});
        if (on && kind == KIND_ACK) chk("data", report.data, 32'h5a5a_a5a5 ^ cmd);
        repeat (2) @(negedge clock);
        chk("held", reportValid, 1'b1);
        if (!on) begin
            svpe_link_partner_inst.sendMsg(cmd, KIND_ACK);
            chk("late kept", report.result, RESULT_TIMEOUT);
        end
        reportTaken = 1'b1;
        @(negedge clock);
        reportTaken = 1'b0;
        waitIdle(powerRoleSource);
        if (!on) begin
            svpe_link_partner_inst.sendMsg(cmd, KIND_ACK);
            repeat (3) @(negedge clock);
            chk("late", reportValid, 1'b0);
        end
        $display("query %0d kind %0d done", cmd, kind);
    endtask : query
    initial begin
        repeat (16) @(posedge clock);
        @(negedge clock);
        rst = 1'b0;
        @(negedge clock);
        for (k = 1; k <= 5; k++) serve(k[2:0], k[0], 1'b0, 2'h0);
        serve(CMD_ENTER, 1'b0, 1'b1, 2'h1);
        serve(CMD_ENTER, 1'b1, 1'b1, 2'h3);
        gateIdentity();
        attention();
        for (k = 0; k < 4; k++) begin
            query(CMD_IDENTITY, k[1:0], k != 0);
            query(CMD_VENDOR_IDS, k[1:0], k != 0);
        end
        wrap_up();
    end
endmodule : structured_vdm_policy_engine_tb
